/* File: rtl/addand_bitclear_skip_exec.sv */
// Execution of four instructions: add and AND of the accumulator with a
// data-memory register, clear of one register bit, and bit test with skip.
// Assumes the fetch path presents one instruction per valid cycle and
// that software uses the plain port only to load and observe state.
//
// Overview of operation
// - AND accumulator with register, update zero flag
// - Destination bit: 0 accumulator, 1 register
// - Seven-bit register address, three-bit bit select
// - Bit clear touches one bit, no flags
// - Bit test skips next when bit zero
// - Skip turns fetched instruction into idle slot
// - Port write-back reads pins, not latch
module addand_bitclear_skip_exec #(
    parameter logic [exec_pkg::FADDR_W-1:0] PORT_ADDR = 7'h06
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire logic [exec_pkg::INSTR_W-1:0] instr,
    input wire logic [exec_pkg::DATA_W-1:0] pin_levels,
    input wire logic [exec_pkg::SW_ADDR_W-1:0] sw_addr,
    input wire logic [exec_pkg::DATA_W-1:0] sw_wdata,
    input wire logic sw_write,
    input wire logic sw_read,
    output logic [exec_pkg::DATA_W-1:0] sw_rdata,
    output logic [exec_pkg::DATA_W-1:0] accumulator,
    output logic [exec_pkg::DATA_W-1:0] port_latch,
    output logic carry,
    output logic nibble_overflow_bit,
    output logic zero,
    output logic skip_slot
);
    import exec_pkg::*;

    localparam int DEPTH = 1 << FADDR_W;

    function automatic op_t decode_op(input logic [INSTR_W-1:0] word);
        op_t op;
        op = OP_NONE_T;
        if (word[INSTR_W-1 -: 6] == OP_ADD) begin
            op = OP_ADD_T;
        end else if (word[INSTR_W-1 -: 6] == OP_AND) begin
            op = OP_AND_T;
        end else if (word[INSTR_W-1 -: 4] == OP_CLEAR) begin
            op = OP_CLEAR_T;
        end else if (word[INSTR_W-1 -: 4] == OP_TEST) begin
            op = OP_TEST_T;
        end
        return op;
    endfunction : decode_op

    logic [DATA_W-1:0] data_mem [DEPTH];
    state_t state;
    state_t next_state;
    logic [DATA_W-1:0] next_accumulator;
    logic [DATA_W-1:0] next_port_latch;
    logic [DATA_W-1:0] next_sw_rdata;
    logic next_carry;
    logic next_nibble_overflow_bit;
    logic next_zero;

    logic mem_we;
    logic [FADDR_W-1:0] mem_waddr;
    logic [DATA_W-1:0] mem_wdata;

    op_t op;
    logic exec;
    logic dest;
    logic [FADDR_W-1:0] reg_addr;
    logic [BSEL_W-1:0] bit_sel;
    logic [DATA_W-1:0] bit_mask;
    logic writes_reg;
    logic [DATA_W-1:0] operand;
    logic [DATA_W:0] sum;
    logic [4:0] low_sum;
    logic [DATA_W-1:0] result;

    // Operand fetch and arithmetic
    always_comb begin
        op = decode_op(instr);
        // A fetched word is dropped while the idle slot runs
        exec = instr_valid && (state == ST_EXEC);
        dest = instr[D_POS];
        reg_addr = instr[F_LSB +: FADDR_W];
        bit_sel = instr[B_LSB +: BSEL_W];
        bit_mask = 8'h01 << bit_sel;
        writes_reg = (op == OP_CLEAR_T)
            || ((op == OP_ADD_T || op == OP_AND_T) && dest == DEST_REG);
        operand = data_mem[reg_addr];
        // Read-modify-write of the port sees the pins, so an input pin
        // held low by the outside writes back a zero
        if (writes_reg && reg_addr == PORT_ADDR) begin
            operand = pin_levels;
        end
        sum = {1'b0, accumulator} + {1'b0, operand};
        low_sum = {1'b0, accumulator[3:0]} + {1'b0, operand[3:0]};
        result = accumulator & operand;
        if (op == OP_ADD_T) begin
            result = sum[DATA_W-1:0];
        end else if (op == OP_CLEAR_T) begin
            result = operand & ~bit_mask;
        end
    end

    // Next-state of accumulator, flags, memory and sequencing
    always_comb begin
        next_state = state;
        next_accumulator = accumulator;
        next_carry = carry;
        next_nibble_overflow_bit = nibble_overflow_bit;
        next_zero = zero;
        next_port_latch = port_latch;
        next_sw_rdata = RDATA_RST;
        mem_we = 1'b0;
        mem_waddr = sw_addr[FADDR_W-1:0];
        mem_wdata = sw_wdata;

        // Software port: load and observe
        if (sw_write) begin
            if (sw_addr < SW_ACC) begin
                mem_we = 1'b1;
            end else if (sw_addr == SW_ACC) begin
                next_accumulator = sw_wdata;
            end else if (sw_addr == SW_FLAGS) begin
                next_carry = sw_wdata[FLAG_C];
                next_nibble_overflow_bit = sw_wdata[FLAG_DC];
                next_zero = sw_wdata[FLAG_Z];
            end
        end
        if (sw_read) begin
            if (sw_addr < SW_ACC) begin
                next_sw_rdata = data_mem[sw_addr[FADDR_W-1:0]];
            end else if (sw_addr == SW_ACC) begin
                next_sw_rdata = accumulator;
            end else if (sw_addr == SW_FLAGS) begin
                next_sw_rdata = {5'h00, zero, nibble_overflow_bit, carry};
            end
        end

        unique case (state)
            ST_EXEC: begin
                // An instruction in the same cycle overrides software
                if (exec && op != OP_NONE_T && op != OP_TEST_T) begin
                    if (writes_reg) begin
                        mem_we = 1'b1;
                        mem_waddr = reg_addr;
                        mem_wdata = result;
                    end else begin
                        next_accumulator = result;
                    end
                end
                if (exec && (op == OP_ADD_T || op == OP_AND_T)) begin
                    next_zero = (result == 8'h00);
                end
                if (exec && op == OP_ADD_T) begin
                    next_carry = sum[DATA_W];
                    next_nibble_overflow_bit = low_sum[4];
                end
                if (exec && op == OP_TEST_T && !operand[bit_sel]) begin
                    next_state = ST_SKIP;
                end
            end
            ST_SKIP: begin
                // Second cycle of a taken skip: an idle operation
                next_state = ST_EXEC;
            end
        endcase

        if (mem_we && mem_waddr == PORT_ADDR) begin
            next_port_latch = mem_wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_EXEC;
            accumulator <= ACC_RST;
            carry <= 1'b0;
            nibble_overflow_bit <= 1'b0;
            zero <= 1'b0;
            port_latch <= LATCH_RST;
            sw_rdata <= RDATA_RST;
        end else begin
            state <= next_state;
            accumulator <= next_accumulator;
            carry <= next_carry;
            nibble_overflow_bit <= next_nibble_overflow_bit;
            zero <= next_zero;
            port_latch <= next_port_latch;
            sw_rdata <= next_sw_rdata;
        end
    end

    // Data memory has no reset; software loads it before use
    always_ff @(posedge clk) begin
        if (mem_we) begin
            data_mem[mem_waddr] <= mem_wdata;
        end
    end

    assign skip_slot = state[1];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic quiet_sw;
    assign quiet_sw = !sw_write;

    sequence s_exec_op(op_t kind);
        exec && op == kind && quiet_sw;
    endsequence

    sequence s_skip_taken;
        s_exec_op(OP_TEST_T) ##0 !operand[bit_sel];
    endsequence

    property p_and_acc;
        s_exec_op(OP_AND_T) ##0 dest == DEST_ACC |=>
            accumulator == $past(accumulator & operand)
            && zero == ($past(accumulator & operand) == 8'h00);
    endproperty
    a_and_acc: assert property (p_and_acc) else $error("and result wrong");

    property p_dest_reg;
        (s_exec_op(OP_AND_T) or s_exec_op(OP_ADD_T)) ##0 dest == DEST_REG
            |=> $stable(accumulator)
            && data_mem[$past(reg_addr)] == $past(result);
    endproperty
    a_dest_reg: assert property (p_dest_reg) else $error("dest select wrong");

    property p_addr_field;
        exec && op != OP_NONE_T |-> reg_addr == instr[6:0]
            && bit_mask == (8'h01 << instr[9:7]);
    endproperty
    a_addr_field: assert property (p_addr_field) else $error("field decode wrong");

    property p_clear;
        s_exec_op(OP_CLEAR_T) |=>
            data_mem[$past(reg_addr)] == ($past(operand) & ~$past(bit_mask))
            && $stable(carry) && $stable(zero) && $stable(nibble_overflow_bit)
            && state == ST_EXEC;
    endproperty
    a_clear: assert property (p_clear) else $error("bit clear wrong");

    property p_test_skip;
        s_exec_op(OP_TEST_T) |=>
            (state == ST_SKIP) == !$past(operand[bit_sel]);
    endproperty
    a_test_skip: assert property (p_test_skip) else $error("skip decision wrong");

    property p_idle_slot;
        s_skip_taken ##1 quiet_sw |=> $stable(accumulator) && $stable(zero)
            && $stable(carry) && state == ST_EXEC;
    endproperty
    a_idle_slot: assert property (p_idle_slot) else $error("idle slot not idle");

    property p_skip_length;
        s_skip_taken |=> skip_slot ##1 !skip_slot;
    endproperty
    a_skip_length: assert property (p_skip_length) else $error("skip not 2 cycles");

    property p_add;
        s_exec_op(OP_ADD_T) ##0 dest == DEST_ACC |=>
            {carry, accumulator} == $past(sum)
            && nibble_overflow_bit == $past(low_sum[4])
            && zero == ($past(sum[7:0]) == 8'h00);
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");

    property p_port_pins;
        s_exec_op(OP_CLEAR_T) ##0 reg_addr == PORT_ADDR |=>
            port_latch == ($past(pin_levels) & ~$past(bit_mask));
    endproperty
    a_port_pins: assert property (p_port_pins) else $error("port not from pins");

    // A bit test changes no data, flag or port whichever way it goes
    property p_test_quiet;
        s_exec_op(OP_TEST_T) |=> $stable(accumulator) && $stable(carry)
            && $stable(zero) && $stable(nibble_overflow_bit) && $stable(port_latch);
    endproperty
    a_test_quiet: assert property (p_test_quiet) else $error("bit test not quiet");

    // The tested register keeps its contents
    property p_test_data;
        s_exec_op(OP_TEST_T) |=> data_mem[$past(reg_addr)] == $past(operand);
    endproperty
    a_test_data: assert property (p_test_data) else $error("bit test wrote data");

    // AND touches only the zero flag, wherever the result goes
    property p_and_flags;
        s_exec_op(OP_AND_T) |=> $stable(carry) && $stable(nibble_overflow_bit)
            && zero == ($past(accumulator & operand) == 8'h00);
    endproperty
    a_and_flags: assert property (p_and_flags) else $error("and flags wrong");

    // Add written back to a register still updates all three flags
    property p_add_reg;
        s_exec_op(OP_ADD_T) ##0 dest == DEST_REG |=> carry == $past(sum[DATA_W])
            && nibble_overflow_bit == $past(low_sum[4])
            && zero == ($past(sum[7:0]) == 8'h00);
    endproperty
    a_add_reg: assert property (p_add_reg) else $error("add flags wrong");
endmodule : addand_bitclear_skip_exec

/* File: rtl/exec_pkg.sv */
// Constants for the add/and/bit-clear/bit-test execution block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package exec_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int BSEL_W = 3;
    localparam int SW_ADDR_W = 8;

    // Instruction field positions
    localparam int F_LSB = 0;
    localparam int D_POS = 7;
    localparam int B_LSB = 7;
    localparam int OP6_LSB = 8;
    localparam int OP4_LSB = 10;

    // Opcode high bits
    localparam logic [5:0] OP_ADD = 6'h07;
    localparam logic [5:0] OP_AND = 6'h05;
    localparam logic [3:0] OP_CLEAR = 4'h4;
    localparam logic [3:0] OP_TEST = 4'h6;

    // Destination select values
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_REG = 1'b1;

    // Software port map: 8'h00..8'h7f reach data memory
    localparam logic [7:0] SW_ACC = 8'h80;
    localparam logic [7:0] SW_FLAGS = 8'h81;
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;

    // Values after reset
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Cycles taken by a bit test whose skip is taken
    localparam int SKIP_CYCLES = 2;

    typedef enum logic [1:0] {
        ST_EXEC = 2'b01,
        ST_SKIP = 2'b10
    } state_t;

    typedef enum logic [2:0] {
        OP_NONE_T,
        OP_ADD_T,
        OP_AND_T,
        OP_CLEAR_T,
        OP_TEST_T
    } op_t;
endpackage : exec_pkg

/* File: testbench/test_addand_bitclear_skip_exec.sv */
// Self-checking bench for the add/and/bit-clear/bit-test execution block.
// Assumes the design reaches its registers through the plain software port.
module test_addand_bitclear_skip_exec;
    timeunit 1ns;
    timeprecision 100ps;
    import exec_pkg::*;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [INSTR_W-1:0] instr = '0;
    logic [DATA_W-1:0] pin_levels = 8'h00;
    logic [SW_ADDR_W-1:0] sw_addr = 8'h00;
    logic [DATA_W-1:0] sw_wdata = 8'h00;
    logic sw_write = 1'b0;
    logic sw_read = 1'b0;
    logic [DATA_W-1:0] sw_rdata, accumulator, port_latch;
    logic carry, nibble_overflow_bit, zero, skip_slot;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    addand_bitclear_skip_exec #(.PORT_ADDR(7'h06)) uut (.clk(clk), .arst_n(arst_n),
        .instr_valid(instr_valid), .instr(instr), .pin_levels(pin_levels),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read),
        .sw_rdata(sw_rdata), .accumulator(accumulator), .port_latch(port_latch),
        .carry(carry), .nibble_overflow_bit(nibble_overflow_bit), .zero(zero),
        .skip_slot(skip_slot));

    always #2 clk = ~clk;

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // Hang guard: the whole sequence needs well under 400 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            conclude();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sw_write <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge clk);
        sw_write <= 1'b0;
    endtask : sw_wr

    task automatic sw_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sw_read <= 1'b1;
        sw_addr <= a;
        @(posedge clk);
        sw_read <= 1'b0;
        #1 check(sw_rdata, exp);
    endtask : sw_chk

    task automatic exec(input logic [13:0] i);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= i;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask : exec

    function automatic logic [13:0] byte_op(logic [5:0] op, logic d, logic [6:0] f);
        return {op, d, f};
    endfunction : byte_op

    function automatic logic [13:0] bit_op(logic [3:0] op, logic [2:0] b, logic [6:0] f);
        return {op, b, f};
    endfunction : bit_op

    task automatic flags_chk(input logic c, input logic dc, input logic z);
        check({5'h00, zero, nibble_overflow_bit, carry}, {5'h00, z, dc, c});
    endtask : flags_chk

    task automatic t_reset();
        check(accumulator, 8'h00);
        check(port_latch, 8'h00);
        check({7'h00, skip_slot}, 8'h00);
        flags_chk(1'b0, 1'b0, 1'b0);
        sw_chk(8'h90, 8'h00);
        #4 check(sw_rdata, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_add();
        sw_wr(SW_ACC, 8'h17);
        sw_wr(8'h10, 8'hc2);
        exec(byte_op(OP_ADD, DEST_ACC, 7'h10));
        check(accumulator, 8'hd9);
        flags_chk(1'b0, 1'b0, 1'b0);
        sw_wr(SW_ACC, 8'hff);
        sw_wr(8'h00, 8'h01);
        exec(byte_op(OP_ADD, DEST_REG, 7'h00));
        check(accumulator, 8'hff);
        flags_chk(1'b1, 1'b1, 1'b1);
        sw_chk(8'h00, 8'h00);
        $display("test add done");
    endtask : t_add

    task automatic t_and();
        sw_wr(SW_ACC, 8'h17);
        exec(byte_op(OP_AND, DEST_REG, 7'h10));
        check(accumulator, 8'h17);
        flags_chk(1'b1, 1'b1, 1'b0);
        sw_chk(8'h10, 8'h02);
        sw_wr(8'h20, 8'he8);
        exec(byte_op(OP_AND, DEST_ACC, 7'h20));
        check(accumulator, 8'h00);
        flags_chk(1'b1, 1'b1, 1'b1);
        sw_chk(8'h20, 8'he8);
        $display("test and done");
    endtask : t_and

    task automatic t_clear();
        sw_wr(SW_FLAGS, 8'h05);
        sw_wr(8'h7f, 8'hc7);
        exec(bit_op(OP_CLEAR, 3'd7, 7'h7f));
        flags_chk(1'b1, 1'b0, 1'b1);
        sw_chk(8'h7f, 8'h47);
        exec(bit_op(OP_CLEAR, 3'd0, 7'h7f));
        sw_chk(8'h7f, 8'h46);
        $display("test clear done");
    endtask : t_clear

    // Bit test followed back to back by an add that is dropped or executed
    task automatic test_then_add(input logic [2:0] b, input logic skip);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= bit_op(OP_TEST, b, 7'h30);
        @(posedge clk);
        instr <= byte_op(OP_ADD, DEST_ACC, 7'h30);
        #1 check({7'h00, skip_slot}, {7'h00, skip});
        @(posedge clk);
        instr_valid <= 1'b0;
        #1 check({7'h00, skip_slot}, 8'h00);
    endtask : test_then_add

    task automatic t_test();
        sw_wr(SW_FLAGS, 8'h05);
        sw_wr(SW_ACC, 8'h01);
        sw_wr(8'h30, 8'h5a);
        test_then_add(3'd0, 1'b1);
        check(accumulator, 8'h01);
        flags_chk(1'b1, 1'b0, 1'b1);
        test_then_add(3'd1, 1'b0);
        check(accumulator, 8'h5b);
        flags_chk(1'b0, 1'b0, 1'b0);
        sw_chk(8'h30, 8'h5a);
        $display("test bit test done");
    endtask : t_test

    task automatic t_port();
        sw_wr(8'h06, 8'hff);
        #1 check(port_latch, 8'hff);
        pin_levels <= 8'h3c;
        exec(bit_op(OP_CLEAR, 3'd2, 7'h06));
        check(port_latch, 8'h38);
        sw_chk(8'h06, 8'h38);
        // A plain read of the port into the accumulator uses the stored value
        sw_wr(SW_ACC, 8'hff);
        exec(byte_op(OP_AND, DEST_ACC, 7'h06));
        check(accumulator, 8'h38);
        // Near-miss opcodes must do nothing
        sw_wr(SW_FLAGS, 8'h07);
        exec(byte_op(6'h06, DEST_ACC, 7'h06));
        exec(bit_op(4'h5, 3'd0, 7'h06));
        check(accumulator, 8'h38);
        check(port_latch, 8'h38);
        flags_chk(1'b1, 1'b1, 1'b1);
        $display("test port done");
    endtask : t_port

    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        #1 t_reset();
        t_add();
        t_and();
        t_clear();
        t_test();
        t_port();
        conclude();
    end
endmodule : test_addand_bitclear_skip_exec
